// *** pbsp_defines.svh ***
`ifndef PBSP_DEFINES_SVH
`define PBSP_DEFINES_SVH

// Array shape
`define PBSP_ADDR_W 17
`define PBSP_DEPTH 131072
`define PBSP_LANES 4
`define PBSP_LANE_W 9
`define PBSP_LANE_DATA_W 8
`define PBSP_DATA_W 32
`define PBSP_WORD_W 36

// Burst counter
`define PBSP_BEAT_W 2
`define PBSP_BEAT_ZERO 2'h0
`define PBSP_BEAT_ONE 2'h1
`define PBSP_OFFSET_LSB 0
`define PBSP_OFFSET_MSB 1
`define PBSP_GROUP_LSB 2

// Pin levels
`define PBSP_RW_READ 1'h1
`define PBSP_ORDER_INTERLEAVED 1'h1

// Write buffer
`define PBSP_WBUF_DEPTH 16
`define PBSP_WBUF_PTR_W 4
`define PBSP_WBUF_CNT_W 5

`endif

// *** pbsp_pkg.sv ***
`include "pbsp_defines.svh"

package pbsp_pkg;

  // One array word: four 9-bit lanes, parity bits above data bits
  typedef struct packed {
    logic [`PBSP_LANES-1:0] parity;
    logic [`PBSP_DATA_W-1:0] data;
  } pbsp_word_s;

  // Write waiting in the buffer for the array port
  typedef struct packed {
    logic [`PBSP_ADDR_W-1:0] addr;
    logic [`PBSP_LANES-1:0] lanes;
    pbsp_word_s word;
  } pbsp_wr_s;

  localparam int PBSP_WR_W = $bits(pbsp_wr_s);

  typedef logic [`PBSP_ADDR_W-1:0] pbsp_addr_t;
  typedef logic [`PBSP_BEAT_W-1:0] pbsp_beat_t;

  // Control state of the port
  typedef struct packed {
    pbsp_addr_t addr;
    pbsp_beat_t start;
    pbsp_beat_t beat;
    logic burst_on;
    logic burst_read;
    logic pend_on;
    logic pend_read;
    pbsp_addr_t pend_addr;
    logic [`PBSP_LANES-1:0] pend_lanes;
  } pbsp_state_s;

endpackage

// *** pbsp_fifo.sv ***
`timescale 1ns/10ps

module pbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int PTR_W = 4,
  parameter int CNT_W = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic [DEPTH-1:0][WIDTH-1:0] peek_data,
  output logic [DEPTH-1:0] peek_valid
);
  typedef struct packed {
    logic [PTR_W-1:0] rd;
    logic [PTR_W-1:0] wr;
    logic [CNT_W-1:0] count;
  } pbsp_fifo_state_s;

  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  pbsp_fifo_state_s state_reg;
  pbsp_fifo_state_s state_next;
  logic push;
  logic pop;

  assign full = (state_reg.count == FULL_COUNT);
  assign out_valid = (state_reg.count != '0);
  assign out_data = store[state_reg.rd];
  // A full buffer still takes a word when one leaves in the same edge
  assign in_ready = ~full | out_ready;
  assign pop = ~hold & out_valid & out_ready;
  assign push = ~hold & in_valid & in_ready;

  // Oldest entry first, so a later match overrides an earlier one
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      peek_data[i] = store[PTR_W'(state_reg.rd + PTR_W'(i))];
      peek_valid[i] = (CNT_W'(i) < state_reg.count);
    end
  end

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wr = state_reg.wr + PTR_W'(1);
    end
    if (pop) begin
      state_next.rd = state_reg.rd + PTR_W'(1);
    end
    state_next.count = state_reg.count + CNT_W'(push) - CNT_W'(pop);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[state_reg.wr] <= in_data;
    end
  end
endmodule

// *** pbsp_port.sv ***
`timescale 1ns/10ps
`include "pbsp_defines.svh"
// Contract
// - Array holds 131072 words of 36 bits in four 9-bit lanes.
// - Address and control taken on one edge; data moves next cycle.
// - Read may follow write, and write follow read, back to back.
// - Read data reaches the pins without an output register.
// - Output gate disables the data drivers at once, without the clock.
// - Drive direction follows the registered read/write state.
// - Clock hold high: other inputs ignored, all registers keep contents.
// - Held edge leaves outputs unchanged, as if it never happened.
// - Deselect with load low starts nothing and ends any burst.
// - Data transfer pending from previous cycle still completes on deselect.
// - Data bus released one cycle after deselect or write start.
// - One loaded address yields four burst addresses; further advances wrap and keep the burst going.
// - Burst order input picks linear or interleaved sequence.
// - Load low takes new address and type; high advances counter.
// - Address register loads only on load, no hold, all selects true.
// - Advance ignores the address pins and steps an active burst.
// - Read/write high reads, low writes; bus activity one clock later.
// - Each 9-bit lane has its own active-low byte write enable.
// - Byte write enables ignored when read/write samples high on a load; write-burst advances take them regardless of read/write.
// - Enabled lanes written with data from the following cycle.
// - Burst order high interleaves, low counts linearly.
// - Two selects active low, third active high, same role.
// - Output gate high keeps all data pins released.
// - Write data captured into an input register on data-cycle edge.

module pbsp_port
  import pbsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire pbsp_pkg::pbsp_addr_t word_address,
  input wire logic read_not_write,
  input wire logic advance_or_load,
  input wire logic clock_hold_n,
  input wire logic select_a_n,
  input wire logic select_b,
  input wire logic select_c_n,
  input wire logic [`PBSP_LANES-1:0] byte_write_n,
  input wire logic burst_order_select,
  input wire logic output_gate_n,
  input wire logic [`PBSP_DATA_W-1:0] data_lines_in,
  output logic [`PBSP_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [`PBSP_LANES-1:0] parity_byte_lines_in,
  output logic [`PBSP_LANES-1:0] parity_byte_lines_out,
  output logic parity_byte_lines_oe
);
  import pbsp_pkg::*;

  pbsp_state_s state_reg;
  pbsp_state_s state_next;

  // Array storage, one 36-bit word per address
  pbsp_word_s array_mem [`PBSP_DEPTH];

  logic hold;
  logic selected;
  logic load_cycle;
  logic deselect_cycle;
  logic advance_cycle;
  logic [`PBSP_LANES-1:0] lanes_sampled;
  pbsp_beat_t beat_step;
  pbsp_beat_t offset_step;
  pbsp_addr_t addr_step;

  logic read_cycle;
  logic write_cycle;
  pbsp_word_s pins_word;
  pbsp_wr_s wbuf_in;
  logic wbuf_in_ready;
  logic wbuf_push;
  logic wbuf_out_valid;
  logic wbuf_out_ready;
  logic [PBSP_WR_W-1:0] wbuf_out_raw;
  pbsp_wr_s wbuf_out;
  logic wbuf_full;
  logic [`PBSP_WBUF_DEPTH-1:0][PBSP_WR_W-1:0] wbuf_peek;
  logic [`PBSP_WBUF_DEPTH-1:0] wbuf_peek_valid;
  pbsp_word_s read_word;
  pbsp_word_s array_word;
  pbsp_word_s drain_old;
  pbsp_word_s drain_word;
  logic [`PBSP_LANES-1:0][`PBSP_LANE_DATA_W-1:0] drain_data;
  logic [`PBSP_LANES-1:0] drain_parity;
  logic [`PBSP_LANES-1:0][`PBSP_LANE_DATA_W-1:0] read_data;
  logic [`PBSP_LANES-1:0] read_parity;

  // Decode of the sampled control pins
  always_comb begin
    hold = clock_hold_n;
    selected = ~select_a_n & select_b & ~select_c_n;
    load_cycle = ~advance_or_load & selected;
    deselect_cycle = ~advance_or_load & ~selected;
    advance_cycle = advance_or_load & state_reg.burst_on;
  end

  // Lanes only count on write cycles; a sampled read masks them all
  always_comb begin
    lanes_sampled = '0;
    if (read_not_write != `PBSP_RW_READ) begin
      lanes_sampled = ~byte_write_n;
    end
  end

  // Burst address: only the two low bits move, the group stays fixed
  always_comb begin
    beat_step = state_reg.beat + `PBSP_BEAT_ONE;
    if (burst_order_select == `PBSP_ORDER_INTERLEAVED) begin
      offset_step = state_reg.start ^ beat_step;
    end else begin
      offset_step = state_reg.start + beat_step;
    end
    addr_step = {state_reg.addr[`PBSP_ADDR_W-1:`PBSP_GROUP_LSB], offset_step};
  end

  always_comb begin
    state_next = state_reg;
    if (!hold) begin
      // A data phase lasts exactly one cycle unless reissued
      state_next.pend_on = 1'b0;
      state_next.pend_lanes = '0;
      if (load_cycle) begin
        state_next.addr = word_address;
        state_next.start = word_address[`PBSP_OFFSET_MSB:`PBSP_OFFSET_LSB];
        state_next.beat = `PBSP_BEAT_ZERO;
        state_next.burst_on = 1'b1;
        state_next.burst_read = (read_not_write == `PBSP_RW_READ);
        state_next.pend_on = 1'b1;
        state_next.pend_read = (read_not_write == `PBSP_RW_READ);
        state_next.pend_addr = word_address;
        state_next.pend_lanes = lanes_sampled;
      end else if (deselect_cycle) begin
        state_next.burst_on = 1'b0;
      end else if (advance_cycle) begin
        // Address pins are not looked at here
        state_next.beat = beat_step;
        state_next.addr = addr_step;
        state_next.pend_on = 1'b1;
        state_next.pend_read = state_reg.burst_read;
        state_next.pend_addr = addr_step;
        if (!state_reg.burst_read) begin
          state_next.pend_lanes = ~byte_write_n;
        end
      end
    end
  end

  // Whole state freezes on a held edge
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Data phase of the access registered on the previous edge
  always_comb begin
    read_cycle = state_reg.pend_on & state_reg.pend_read;
    write_cycle = state_reg.pend_on & ~state_reg.pend_read;
  end

  always_comb begin
    pins_word.data = data_lines_in;
    pins_word.parity = parity_byte_lines_in;
    wbuf_in.addr = state_reg.pend_addr;
    wbuf_in.lanes = state_reg.pend_lanes;
    wbuf_in.word = pins_word;
    wbuf_out = pbsp_wr_s'(wbuf_out_raw);
  end

  // Buffer entries act as the data-in register on the data-cycle edge
  assign wbuf_push = write_cycle & wbuf_in_ready;

  // Reads own the array port; a full buffer takes it back so it drains
  assign wbuf_out_ready = ~read_cycle | wbuf_full;

  pbsp_fifo #(
    .WIDTH(PBSP_WR_W),
    .DEPTH(`PBSP_WBUF_DEPTH),
    .PTR_W(`PBSP_WBUF_PTR_W),
    .CNT_W(`PBSP_WBUF_CNT_W)
  ) u_wbuf (
    .clk(clk),
    .reset(reset),
    .hold(hold),
    .in_valid(wbuf_push),
    .in_ready(wbuf_in_ready),
    .in_data(PBSP_WR_W'(wbuf_in)),
    .out_valid(wbuf_out_valid),
    .out_ready(wbuf_out_ready),
    .out_data(wbuf_out_raw),
    .full(wbuf_full),
    .peek_data(wbuf_peek),
    .peek_valid(wbuf_peek_valid)
  );

  // Stored word under the drain address, before its lanes are merged
  assign drain_old = array_mem[wbuf_out.addr];

  // Lanes merge before one store; a store per lane would keep only the last
  for (genvar l = 0; l < `PBSP_LANES; l++) begin : g_drain_lane
    assign drain_data[l] = wbuf_out.lanes[l] ?
      wbuf_out.word.data[l*`PBSP_LANE_DATA_W +: `PBSP_LANE_DATA_W] :
      drain_old.data[l*`PBSP_LANE_DATA_W +: `PBSP_LANE_DATA_W];
    assign drain_parity[l] = wbuf_out.lanes[l] ?
      wbuf_out.word.parity[l] :
      drain_old.parity[l];
  end

  assign drain_word = {drain_parity, drain_data};

  // Drain one buffered write per free cycle into the array
  always_ff @(posedge clk) begin
    if (!hold && wbuf_out_valid && wbuf_out_ready) begin
      array_mem[wbuf_out.addr] <= drain_word;
    end
  end

  assign array_word = array_mem[state_reg.pend_addr];

  // Per lane, the newest buffered write to the read address wins
  for (genvar l = 0; l < `PBSP_LANES; l++) begin : g_read_lane
    logic [`PBSP_LANE_DATA_W-1:0] lane_data;
    logic lane_parity;
    always_comb begin
      pbsp_wr_s entry;
      entry = '0;
      lane_data = array_word.data[l*`PBSP_LANE_DATA_W +: `PBSP_LANE_DATA_W];
      lane_parity = array_word.parity[l];
      for (int i = 0; i < `PBSP_WBUF_DEPTH; i++) begin
        entry = pbsp_wr_s'(wbuf_peek[i]);
        if (wbuf_peek_valid[i] && entry.lanes[l] && entry.addr == state_reg.pend_addr) begin
          lane_data = entry.word.data[l*`PBSP_LANE_DATA_W +: `PBSP_LANE_DATA_W];
          lane_parity = entry.word.parity[l];
        end
      end
    end
    assign read_data[l] = lane_data;
    assign read_parity[l] = lane_parity;
  end

  assign read_word = {read_parity, read_data};

  // Flow-through path; the gate acts with no clock in between
  always_comb begin
    data_lines_out = read_word.data;
    parity_byte_lines_out = read_word.parity;
    data_lines_oe = read_cycle & ~output_gate_n;
    parity_byte_lines_oe = read_cycle & ~output_gate_n;
  end
endmodule

// *** pbsp_port_chk.sv ***
`timescale 1ns/10ps
`include "pbsp_defines.svh"
module pbsp_port_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic read_not_write,
  input wire logic advance_or_load,
  input wire logic clock_hold_n,
  input wire logic select_a_n,
  input wire logic select_b,
  input wire logic select_c_n,
  input wire logic output_gate_n,
  input wire logic [`PBSP_DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic parity_byte_lines_oe
);
  logic sel, go, ld_rd, ld_wr, dsel;
  assign sel = !select_a_n && select_b && !select_c_n;
  assign go = !clock_hold_n;
  assign ld_rd = go && !advance_or_load && sel && read_not_write;
  assign ld_wr = go && !advance_or_load && sel && !read_not_write;
  assign dsel = go && !advance_or_load && !sel;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_read_drive: assert property (ld_rd |=> data_lines_oe || output_gate_n)
    else $error("read phase not driven");
  a_write_release: assert property (ld_wr |=> !data_lines_oe)
    else $error("write phase driven");
  a_desel_release: assert property (dsel |=> !data_lines_oe)
    else $error("deselect phase driven");
  a_gate_off: assert property (output_gate_n |-> !data_lines_oe && !parity_byte_lines_oe)
    else $error("gate high but driving");
  a_lanes_pair: assert property (data_lines_oe == parity_byte_lines_oe)
    else $error("lane enables differ");
  a_hold_freeze: assert property (!output_gate_n && clock_hold_n ##1 !output_gate_n |->
    $stable(data_lines_oe) && (!data_lines_oe || $stable(data_lines_out)))
    else $error("held edge changed outputs");
  a_burst_step: assert property (ld_rd ##1 (go && advance_or_load) |=>
    data_lines_oe || output_gate_n)
    else $error("burst beat not driven");
  a_rise_cause: assert property ($rose(data_lines_oe) |->
    $past(ld_rd) || $fell(output_gate_n))
    else $error("drive without read");
endmodule
bind pbsp_port pbsp_port_chk chk_i (
  .clk, .reset, .read_not_write, .advance_or_load, .clock_hold_n, .select_a_n,
  .select_b, .select_c_n, .output_gate_n, .data_lines_out, .data_lines_oe,
  .parity_byte_lines_oe
);

// *** pbsp_ctl_model.sv ***
`timescale 1ns/10ps
module pbsp_ctl_model
  import pbsp_pkg::*;
(
  input wire logic clk,
  input wire logic bus_oe,
  input wire pbsp_pkg::pbsp_word_s bus_rd,
  output pbsp_pkg::pbsp_addr_t word_address,
  output logic read_not_write,
  output logic advance_or_load,
  output logic clock_hold_n,
  output logic [2:0] sel,
  output logic [3:0] byte_write_n,
  output pbsp_pkg::pbsp_word_s bus_wr
);
  import pbsp_pkg::*;
  logic got_oe;
  pbsp_word_s got;
  initial begin
    {word_address, read_not_write, advance_or_load, clock_hold_n} = 20'h0;
    sel = 3'h5;
    byte_write_n = 4'hF;
    bus_wr = 36'h0;
  end
  // c is drive, hold, advance, read; sampling precedes driving
  task automatic step(input logic [3:0] c, input logic [2:0] s, input logic [3:0] bw,
      input pbsp_addr_t a, input pbsp_word_s d);
    @(posedge clk);
    #1;
    got_oe = bus_oe;
    got = bus_rd;
    {clock_hold_n, advance_or_load, read_not_write} = c[2:0];
    sel = s;
    byte_write_n = bw;
    word_address = a;
    // Released bus shows the inverse so a stale word cannot pass
    bus_wr = c[3] ? d : ~bus_wr;
  endtask
endmodule

// *** tb_pipelined_burst_sram_port.sv ***
`timescale 1ns/10ps
module tb_pipelined_burst_sram_port;
  import pbsp_pkg::*;
  localparam logic [3:0] LDW = 4'h0, LDR = 4'h1, ADV = 4'h2, HLD = 4'h4, DRV = 4'h8;
  localparam logic [2:0] ON = 3'h2, OFF = 3'h5;
  localparam pbsp_addr_t B = 17'h00104;
  logic clk, reset, order, gate_n, rw, adv, hold, d_oe, p_oe;
  int fails = 0;
  int tests_run = 0;
  pbsp_addr_t a;
  logic [2:0] sel;
  logic [3:0] bw, p_out, p_in;
  logic [31:0] d_out, d_in;
  pbsp_word_s wr;
  assign d_in = d_oe ? d_out : wr.data;
  assign p_in = p_oe ? p_out : wr.parity;
  pbsp_port DUT (
    .clk, .reset, .word_address(a), .read_not_write(rw), .advance_or_load(adv),
    .clock_hold_n(hold), .select_a_n(sel[2]), .select_b(sel[1]), .select_c_n(sel[0]),
    .byte_write_n(bw), .burst_order_select(order), .output_gate_n(gate_n),
    .data_lines_in(d_in), .data_lines_out(d_out), .data_lines_oe(d_oe),
    .parity_byte_lines_in(p_in), .parity_byte_lines_out(p_out), .parity_byte_lines_oe(p_oe)
  );
  pbsp_ctl_model ctl (
    .clk, .bus_oe(d_oe), .bus_rd({p_out, d_out}), .word_address(a), .read_not_write(rw),
    .advance_or_load(adv), .clock_hold_n(hold), .sel, .byte_write_n(bw), .bus_wr(wr)
  );
  function automatic pbsp_word_s pat(input logic [7:0] k);
    return {k[3:0], {4{k}}};
  endfunction
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic st(input logic [3:0] c, input logic [2:0] s, input pbsp_addr_t x);
    ctl.step(c, s, 4'h0, x, 36'h0);
  endtask
  task automatic t_turn();
    pbsp_word_s e;
    e = pat(8'h01);
    e.data[7:0] = 8'h02;
    e.parity[0] = 1'b0;
    st(LDW, ON, B);
    ctl.step(DRV | LDR, ON, 4'h0, B, pat(8'h01));
    chk(ctl.got_oe === 1'b0, "write phase driven");
    ctl.step(LDW, ON, 4'hE, B, 36'h0);
    chk(ctl.got === pat(8'h01), "read after write");
    ctl.step(DRV | LDR, ON, 4'h0, B, pat(8'h02));
    st(LDR, OFF, B);
    chk(ctl.got === e, "lane write");
    st(LDR, OFF, B);
    chk(ctl.got_oe === 1'b0, "deselect driven");
    $display("t_turn end");
  endtask
  task automatic t_burst();
    st(LDW, ON, B);
    for (int k = 0; k < 3; k++) ctl.step(DRV | ADV, ON, 4'h0, 17'h1FFFF, pat(8'(16 + k)));
    ctl.step(DRV | LDR, OFF, 4'h0, B, pat(8'h13));
    for (int o = 0; o < 2; o++) begin
      order = o[0];
      st(LDR, ON, B + 17'h1);
      for (int k = 0; k < 4; k++) begin
        st(k < 3 ? ADV : LDR, k < 3 ? ON : OFF, 17'h1FFFF);
        chk(ctl.got === pat(8'(16 + (o ? (1 ^ k) : (1 + k) % 4))), "beat");
      end
    end
    $display("t_burst end");
  endtask
  task automatic t_hold();
    order = 1'b0;
    st(LDR, ON, B + 17'h2);
    for (int k = 0; k < 3; k++) begin
      st(k < 2 ? HLD : ADV, ON, 17'h0);
      chk(ctl.got === pat(8'h12) && ctl.got_oe === 1'b1, "held read");
    end
    st(LDR, OFF, B);
    chk(ctl.got === pat(8'h13), "beat after hold");
    $display("t_hold end");
  endtask
  task automatic t_desel();
    for (int i = 0; i < 3; i++) begin
      st(LDR, ON, B);
      st(LDR, ON ^ 3'(1 << i), B);
      chk(ctl.got_oe === 1'b1 && ctl.got === pat(8'h10), "pending read lost");
      st(ADV, ON, B);
      chk(ctl.got_oe === 1'b0, "driven after deselect");
      st(LDR, OFF, B);
      chk(ctl.got_oe === 1'b0, "advance revived burst");
    end
    $display("t_desel end");
  endtask
  task automatic t_gate();
    st(LDR, ON, B);
    st(ADV, ON, B);
    chk(d_oe === 1'b1 && ctl.got === pat(8'h10), "gated read");
    gate_n = 1'b1;
    #1 chk(d_oe === 1'b0 && p_oe === 1'b0, "gate ignored");
    st(LDR, OFF, B);
    chk(ctl.got_oe === 1'b0, "gated edge driven");
    gate_n = 1'b0;
    #1 chk(d_oe === 1'b1 && d_out === pat(8'h11).data, "ungated beat");
    st(LDR, OFF, B);
    $display("t_gate end");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    fails++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    order = 1'b0;
    gate_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    t_turn();
    t_burst();
    t_hold();
    t_desel();
    t_gate();
    test_done();
  end
endmodule
